/* File: core/gwie_top.sv */
// wake enable and interrupt endpoint event control with wishbone slave
//
// How it works
// RL1 - bit 31 lets pin seven flag link-up in suspend
// RL2 - polarity 0 triggers low, 1 triggers high
// RL3 - pin n polarity sits at bit 16+n
// RL4 - polarity bits reset to zero, read/write
// RL5 - wake-enable bit n gates pin n wake
// RL6 - pins in alternate function never wake
// RL7 - wake field defaults from eeprom, else zero
// RL8 - usb or lite reset restores eeprom image
// RL9 - reset protection can keep wake field
// RL10 - always-on bit sends packet every interval
// RL11 - enables for mac timeout, rx fifo, stops
// RL12 - enables for phy, tx errors, rx drop
// RL13 - per-pin interrupt enable in bits 10:0
// RL14 - disabled events never request a packet
// RL15 - enabled events latch until next interval
// RL16 - reserved bits read zero, writes ignored
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module gwie_top (
  input  wire logic         CLK_SYS,
  input  wire logic         SYS_RST,
  input  wire logic         CE,
  // classic wishbone slave
  input  wire logic         WB_CYC_I,
  input  wire logic         WB_STB_I,
  input  wire logic         WB_WE_I,
  input  wire logic [7:0]   WB_ADR_I,
  input  wire logic [3:0]   WB_SEL_I,
  input  wire logic [31:0]  WB_DAT_I,
  output logic      [31:0]  WB_DAT_O,
  output logic              WB_ACK_O,
  // pins and their function selection
  input  wire logic [10:0]  PIN_IN,
  input  wire logic [10:0]  PIN_IS_GPIO,
  // suspend state indications from the power logic
  input  wire logic         SUSPEND_STATE_ZERO,
  input  wire logic         SUSPEND_STATE_THREE,
  // device-level event pulses, bit 8 mac timeout .. bit 0 rx dropped
  input  wire logic [8:0]   EVENT_PULSE,
  // eeprom image of the wake field
  input  wire logic         EEPROM_LOADED,
  input  wire logic         EEPROM_PRESENT,
  input  wire logic [15:0]  EEPROM_WAKE_IMAGE,
  // soft resets and protection
  input  wire logic         USB_RESET,
  input  wire logic         LITE_RESET,
  input  wire logic         PROTECT_USB_RESET,
  input  wire logic         PROTECT_LITE_RESET,
  // interrupt endpoint interval tick and packet request
  input  wire logic         EP_INTERVAL_TICK,
  output logic              EP_PACKET_SEND,
  output logic      [19:0]  EP_PACKET_STATUS,
  // wake outputs
  output logic              WAKE_REQUEST,
  output logic              LINK_UP_WAKE,
  output logic              IRQ
);

  gwie_pkg::gwie_wb_req_t req;
  gwie_pkg::gwie_ctl_t    ctl_q;
  logic [10:0]            eeprom_img_q;
  logic [10:0]            pin_active;
  logic [10:0]            pin_evt_q;
  logic [10:0]            pin_evt_prev_q;
  logic [19:0]            pending_q;
  logic [19:0]            raw_evt;
  logic [19:0]            en_mask;
  logic [2:0]             irq_stat_q;
  logic [2:0]             irq_en_q;
  logic [2:0]             irq_set;
  logic [31:0]            rd_data;
  logic [31:0]            wmask;
  logic                   access;
  logic                   wr_wake;
  logic                   wr_ctl;
  logic                   wr_clr;
  logic                   wr_ien;
  logic                   soft_rst;
  logic                   wake_d;
  logic                   link_d;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                 adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

  // one access per request; ack drops the cycle after it is given
  assign access  = req.cyc & req.stb & ~WB_ACK_O;
  assign wr_wake = access & req.we & (req.adr == gwie_pkg::OFF_WAKE);
  assign wr_ctl  = access & req.we & (req.adr == gwie_pkg::OFF_EPCTL);
  assign wr_clr  = access & req.we & (req.adr == gwie_pkg::OFF_IRQ_CLEAR);
  assign wr_ien  = access & req.we & (req.adr == gwie_pkg::OFF_IRQ_ENABLE);

  // byte-lane write mask from sel
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_sel
      assign wmask[8*b +: 8] = {8{req.sel[b]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pins

  gwie_pin_sync #(
    .WIDTH     (gwie_pkg::NUM_PINS)
  ) u_pin_sync (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .ce        (CE),
    .pin_async (PIN_IN),
    .polarity  (ctl_q.pin_trigger_polarity),
    .active    (pin_active)
  );

  // a pin not in gpio function is masked before anything sees it
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_evt_q      <= '0;
      pin_evt_prev_q <= '0;
    end
    else if (CE)
    begin
      pin_evt_q      <= pin_active & PIN_IS_GPIO; // RL6
      pin_evt_prev_q <= pin_evt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eeprom image capture

  // capture the image after load; absent eeprom loads zero
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      eeprom_img_q <= gwie_pkg::RST_WAKE;
    else if (CE && EEPROM_LOADED)
      eeprom_img_q <= EEPROM_PRESENT ? EEPROM_WAKE_IMAGE[10:0] // RL7
                                     : gwie_pkg::RST_WAKE;
  end

  // a protected reset kind is simply not counted
  assign soft_rst = (USB_RESET & ~PROTECT_USB_RESET)     // RL9
                  | (LITE_RESET & ~PROTECT_LITE_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // wake and endpoint control registers

  // one process for both: ctl_q is a single packed word, so a second
  // process writing other fields of it would make a second driver
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctl_q.link_up_wake_enable        <= 1'b0;
      ctl_q.pin_trigger_polarity       <= gwie_pkg::RST_POL; // RL4
      ctl_q.pin_wake_enable            <= gwie_pkg::RST_WAKE;
      ctl_q.interrupt_packet_always_on <= 1'b0; // RL10
      ctl_q.event_enable               <= gwie_pkg::RST_EVT_EN;
      ctl_q.pin_interrupt_enable       <= gwie_pkg::RST_PIN_EN;
    end
    else if (CE)
    begin
      if (EEPROM_LOADED)
        ctl_q.pin_wake_enable <= EEPROM_PRESENT ? EEPROM_WAKE_IMAGE[10:0]
                                                : gwie_pkg::RST_WAKE; // RL7
      else if (soft_rst)
        ctl_q.pin_wake_enable <= eeprom_img_q; // RL8
      else if (wr_wake)
        ctl_q.pin_wake_enable <=
          (ctl_q.pin_wake_enable & ~wmask[10:0])
          | (req.dat[10:0] & wmask[10:0]);
      if (wr_wake && req.sel[3])
        ctl_q.link_up_wake_enable <= req.dat[gwie_pkg::POS_LINKUP]; // RL1
      if (wr_wake)
        ctl_q.pin_trigger_polarity <=
          (ctl_q.pin_trigger_polarity & ~wmask[26:16])
          | (req.dat[26:16] & wmask[26:16]); // RL3
      // endpoint control fields
      if (wr_ctl && req.sel[3])
        ctl_q.interrupt_packet_always_on <= req.dat[gwie_pkg::POS_ALWAYS_ON];
      if (wr_ctl)
      begin
        ctl_q.event_enable <= (ctl_q.event_enable & ~wmask[19:11])
                            | (req.dat[19:11] & wmask[19:11]); // RL11 RL12
        ctl_q.pin_interrupt_enable <=
          (ctl_q.pin_interrupt_enable & ~wmask[10:0])
          | (req.dat[10:0] & wmask[10:0]); // RL13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // endpoint event latch and packet

  // pin events count on the rising edge of the active level
  assign raw_evt = {EVENT_PULSE, pin_evt_q & ~pin_evt_prev_q};
  assign en_mask = {ctl_q.event_enable, ctl_q.pin_interrupt_enable};

  // enabled events wait for the next poll; a new event wins over the
  // clear done at the interval tick so nothing is lost
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      pending_q <= '0;
    else if (CE)
      pending_q <= (EP_INTERVAL_TICK ? 20'h00000 : pending_q)
                 | (raw_evt & en_mask); // RL14 RL15
  end

  // packet at a tick when always-on or something is pending
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      EP_PACKET_SEND   <= 1'b0;
      EP_PACKET_STATUS <= '0;
    end
    else if (CE)
    begin
      EP_PACKET_SEND   <= EP_INTERVAL_TICK
                        & (ctl_q.interrupt_packet_always_on // RL10
                           | (|pending_q));
      if (EP_INTERVAL_TICK)
        EP_PACKET_STATUS <= pending_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake outputs

  assign wake_d = |(pin_evt_q & ctl_q.pin_wake_enable); // RL5
  assign link_d = ctl_q.link_up_wake_enable
                & pin_evt_q[gwie_pkg::LINK_PIN]
                & (SUSPEND_STATE_ZERO | SUSPEND_STATE_THREE); // RL1

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      WAKE_REQUEST <= 1'b0;
      LINK_UP_WAKE <= 1'b0;
    end
    else if (CE)
    begin
      WAKE_REQUEST <= wake_d;
      LINK_UP_WAKE <= link_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local interrupt status, clear and enable

  assign irq_set = {link_d & ~LINK_UP_WAKE, wake_d & ~WAKE_REQUEST,
                    EP_INTERVAL_TICK & (|pending_q)};

  // set beats a clear arriving in the same cycle
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      IRQ        <= 1'b0;
    end
    else if (CE)
    begin
      irq_stat_q <= (irq_stat_q & ~(wr_clr ? req.dat[2:0] & wmask[2:0]
                                           : 3'h0)) | irq_set;
      if (wr_ien)
        irq_en_q <= (irq_en_q & ~wmask[2:0]) | (req.dat[2:0] & wmask[2:0]);
      IRQ        <= |(irq_stat_q & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge

  // reserved bits and unmapped addresses read zero
  always_comb
  begin
    rd_data = 32'h00000000;
    case (req.adr)
      gwie_pkg::OFF_WAKE:
      begin
        rd_data[31]    = ctl_q.link_up_wake_enable;
        rd_data[26:16] = ctl_q.pin_trigger_polarity;
        rd_data[10:0]  = ctl_q.pin_wake_enable; // RL16
      end
      gwie_pkg::OFF_EPCTL:
      begin
        rd_data[31]    = ctl_q.interrupt_packet_always_on;
        rd_data[19:11] = ctl_q.event_enable;
        rd_data[10:0]  = ctl_q.pin_interrupt_enable; // RL16
      end
      gwie_pkg::OFF_IRQ_STATUS: rd_data[2:0] = irq_stat_q;
      gwie_pkg::OFF_IRQ_ENABLE: rd_data[2:0] = irq_en_q;
      default:                  rd_data = 32'h00000000;
    endcase
  end

  // every address is acked one cycle after the request
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end
    else if (CE)
    begin
      WB_ACK_O <= access;
      if (access && !req.we)
        WB_DAT_O <= rd_data;
    end
  end

endmodule // gwie_top

/* File: shared/gwie_pkg.sv */
// package: register map, field layout, reset values and carriers
package gwie_pkg;

  localparam int          NUM_PINS        = 11;
  localparam int          NUM_EVENTS      = 9;
  // register byte offsets
  localparam logic [7:0]  OFF_WAKE        = 8'h64;
  localparam logic [7:0]  OFF_EPCTL       = 8'h68;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h80;
  localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h84;
  localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h88;
  // field positions
  localparam int          POS_LINKUP      = 31;
  localparam int          POS_POL_LO      = 16;
  localparam int          POS_WAKE_LO     = 0;
  localparam int          POS_ALWAYS_ON   = 31;
  localparam int          POS_EVT_LO      = 11;
  localparam int          POS_PINEN_LO    = 0;
  localparam int          LINK_PIN        = 7;
  // reset values
  localparam logic [10:0] RST_POL         = 11'h000;
  localparam logic [10:0] RST_WAKE        = 11'h000;
  localparam logic [8:0]  RST_EVT_EN      = 9'h000;
  localparam logic [10:0] RST_PIN_EN      = 11'h000;
  // interrupt status bits
  localparam int          IRQ_PACKET      = 0;
  localparam int          IRQ_WAKE        = 1;
  localparam int          IRQ_LINKUP      = 2;
  localparam int          IRQ_BITS        = 3;

  // wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } gwie_wb_req_t;

  // control fields held by the two documented registers
  typedef struct packed {
    logic        link_up_wake_enable;
    logic [10:0] pin_trigger_polarity;
    logic [10:0] pin_wake_enable;
    logic        interrupt_packet_always_on;
    logic [8:0]  event_enable;
    logic [10:0] pin_interrupt_enable;
  } gwie_ctl_t;

endpackage

/* File: core/gwie_pin_sync.sv */
// two-stage synchroniser and polarity match for the pin inputs
`timescale 1ns/1ps
module gwie_pin_sync #(
  parameter int WIDTH = 11
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_async,
  input  wire logic [WIDTH-1:0] polarity,
  output logic      [WIDTH-1:0] active
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage read only by the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (ce)
    begin
      meta_q <= pin_async;
      sync_q <= meta_q;
    end
  end

  // polarity 0 means low level active, 1 means high level active
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pol
      assign active[i] = ~(sync_q[i] ^ polarity[i]); // RL2
    end
  endgenerate

endmodule // gwie_pin_sync

/* File: tb/gwie_properties.sv */
// checker: port-level properties of the wake and endpoint control block
`timescale 1ns/1ps
module gwie_properties (
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic        CE,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [10:0] PIN_IS_GPIO,
  input wire logic        SUSPEND_STATE_ZERO,
  input wire logic        SUSPEND_STATE_THREE,
  input wire logic        EP_INTERVAL_TICK,
  input wire logic        EP_PACKET_SEND,
  input wire logic        WAKE_REQUEST,
  input wire logic        LINK_UP_WAKE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////
  // multi-step causes
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;
  endsequence
  sequence s_rd;
    WB_ACK_O && !WB_WE_I;
  endsequence
  // two cycles cover the registered output stage
  sequence s_no_suspend;
    (!SUSPEND_STATE_ZERO && !SUSPEND_STATE_THREE) [*2];
  endsequence
  sequence s_no_gpio;
    (PIN_IS_GPIO == 11'h000) [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_ack_next; s_take |=> WB_ACK_O; endproperty
  property p_ack_pulse; WB_ACK_O && CE |=> !WB_ACK_O; endproperty
  property p_send_tick; EP_PACKET_SEND |-> $past(EP_INTERVAL_TICK);
  endproperty
  property p_send_pulse;
    EP_PACKET_SEND && !EP_INTERVAL_TICK |=> !EP_PACKET_SEND;
  endproperty
  property p_link_susp; s_no_suspend |-> !LINK_UP_WAKE; endproperty
  property p_gpio_only; s_no_gpio |-> !WAKE_REQUEST; endproperty
  property p_rsv_wake;
    s_rd and WB_ADR_I == gwie_pkg::OFF_WAKE
      |-> WB_DAT_O[30:27] == 4'h0 && WB_DAT_O[15:11] == 5'h00;
  endproperty
  property p_rsv_epctl;
    s_rd and WB_ADR_I == gwie_pkg::OFF_EPCTL |-> WB_DAT_O[30:20] == 11'h000;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  a_send_tick: assert property (p_send_tick)
    else $error("packet without tick");
  a_send_pulse: assert property (p_send_pulse)
    else $error("packet request long");
  a_link_susp: assert property (p_link_susp)
    else $error("link wake outside suspend");
  a_gpio_only: assert property (p_gpio_only)
    else $error("wake from non gpio pin");
  a_rsv_wake: assert property (p_rsv_wake)
    else $error("reserved wake bits set");
  a_rsv_epctl: assert property (p_rsv_epctl)
    else $error("reserved control bits set");
endmodule // gwie_properties

bind gwie_top gwie_properties u_gwie_properties (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PIN_IS_GPIO(PIN_IS_GPIO),
  .SUSPEND_STATE_ZERO(SUSPEND_STATE_ZERO),
  .SUSPEND_STATE_THREE(SUSPEND_STATE_THREE),
  .EP_INTERVAL_TICK(EP_INTERVAL_TICK), .EP_PACKET_SEND(EP_PACKET_SEND),
  .WAKE_REQUEST(WAKE_REQUEST), .LINK_UP_WAKE(LINK_UP_WAKE));

/* File: tb/gwie_host_poll.sv */
// host model: polls the interrupt endpoint at a fixed interval
`timescale 1ns/1ps
module gwie_host_poll #(
  parameter int INTERVAL = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        send,
  input  wire logic [19:0] status,
  output logic             tick,
  output logic [19:0]      last_status,
  output logic [31:0]      pkt_cnt
);
  int cnt_q;
  // poll slot every interval; the host never skips one
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_q <= 0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == INTERVAL - 1) ? 0 : cnt_q + 1;
      tick  <= (cnt_q == INTERVAL - 1);
    end
  // collect each packet the device hands over
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      pkt_cnt     <= 32'h0;
      last_status <= 20'h0;
    end
    else if (send)
    begin
      pkt_cnt     <= pkt_cnt + 32'h1;
      last_status <= status;
    end
endmodule // gwie_host_poll

/* File: tb/testbench.sv */
// self-checking bench for the wake and endpoint control block
`timescale 1ns/1ps
module testbench;
  logic                   clk;
  logic                   rst;
  gwie_pkg::gwie_wb_req_t req;
  logic [31:0]            rdat;
  logic                   ack;
  logic [10:0]            pin;
  logic [10:0]            gpio;
  logic                   s0;
  logic                   s3;
  logic [8:0]             ev;
  logic                   ld;
  logic                   usb_rst;
  logic                   lite_rst;
  logic                   prot;
  logic                   prot_usb;
  logic                   pres;
  logic                   tick;
  logic                   send;
  logic [19:0]            status;
  logic                   wake;
  logic                   link;
  logic                   irq;
  logic [19:0]            last;
  logic [31:0]            pkts;
  logic [31:0]            q;
  logic [31:0]            c;
  int                     error_cnt;
  int                     samples_checked;

  // clock enable stays fixed high
  gwie_top u_gwie_top (
    .CLK_SYS(clk), .SYS_RST(rst), .CE(1'b1), .WB_CYC_I(req.cyc),
    .WB_STB_I(req.stb), .WB_WE_I(req.we), .WB_ADR_I(req.adr),
    .WB_SEL_I(req.sel), .WB_DAT_I(req.dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PIN_IN(pin), .PIN_IS_GPIO(gpio),
    .SUSPEND_STATE_ZERO(s0), .SUSPEND_STATE_THREE(s3), .EVENT_PULSE(ev),
    .EEPROM_LOADED(ld), .EEPROM_PRESENT(pres),
    .EEPROM_WAKE_IMAGE(16'hFC05), .USB_RESET(usb_rst),
    .LITE_RESET(lite_rst), .PROTECT_USB_RESET(prot_usb),
    .PROTECT_LITE_RESET(prot), .EP_INTERVAL_TICK(tick),
    .EP_PACKET_SEND(send), .EP_PACKET_STATUS(status),
    .WAKE_REQUEST(wake), .LINK_UP_WAKE(link), .IRQ(irq));

  gwie_host_poll u_gwie_host_poll (
    .clk(clk), .rst(rst), .send(send), .status(status), .tick(tick),
    .last_status(last), .pkt_cnt(pkts));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; leading edge gives the gap the slave needs
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    req <= '0;
    if (ack !== 1'b1)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fields();
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h0);
    wb(0, gwie_pkg::OFF_EPCTL, 0);
    chk(q, 32'h0);
    wb(1, gwie_pkg::OFF_WAKE, 32'hFFFFFFFF);
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h87FF07FF);
    wb(1, gwie_pkg::OFF_EPCTL, 32'hFFFFFFFF);
    wb(0, gwie_pkg::OFF_EPCTL, 0);
    chk(q, 32'h800FFFFF);
    wb(1, 8'h70, 32'hFFFFFFFF);
    wb(0, 8'h70, 0);
    chk(q, 32'h0);
  endtask

  // eeprom image reload, then soft resets with and without protection
  task automatic t_soft();
    ld <= 1'b1;
    step(1);
    ld <= 1'b0;
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q & 32'h7FF, 32'h405);
    wb(1, gwie_pkg::OFF_WAKE, 0);
    usb_rst <= 1'b1;
    step(1);
    usb_rst <= 1'b0;
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h405);
    wb(1, gwie_pkg::OFF_WAKE, 0);
    prot <= 1'b1;
    lite_rst <= 1'b1;
    step(1);
    lite_rst <= 1'b0;
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h0);
    // protected usb reset keeps the field as well
    wb(1, gwie_pkg::OFF_WAKE, 32'h000007FF);
    prot_usb <= 1'b1;
    usb_rst <= 1'b1;
    step(1);
    usb_rst <= 1'b0;
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h7FF);
    // absent eeprom: load gives zero, later usb reset restores zero
    prot_usb <= 1'b0;
    pres <= 1'b0;
    ld <= 1'b1;
    step(1);
    ld <= 1'b0;
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h0);
    wb(1, gwie_pkg::OFF_WAKE, 32'h000007FF);
    usb_rst <= 1'b1;
    step(1);
    usb_rst <= 1'b0;
    wb(0, gwie_pkg::OFF_WAKE, 0);
    chk(q, 32'h0);
    pres <= 1'b1;
  endtask

  // pin two: polarity, wake gate and function selection
  task automatic t_pin();
    wb(1, gwie_pkg::OFF_WAKE, 32'h00040004);
    gpio <= 11'h7FF;
    step(8);
    chk({31'h0, wake}, 32'h0);
    pin <= 11'h004;
    step(8);
    chk({31'h0, wake}, 32'h1);
    wb(1, gwie_pkg::OFF_WAKE, 32'h00040000);
    step(8);
    chk({31'h0, wake}, 32'h0);
    wb(1, gwie_pkg::OFF_WAKE, 32'h00000004);
    pin <= 11'h000;
    step(8);
    chk({31'h0, wake}, 32'h1);
    gpio <= 11'h000;
    step(8);
    chk({31'h0, wake}, 32'h0);
  endtask

  task automatic t_link();
    wb(1, gwie_pkg::OFF_WAKE, 32'h80800000);
    pin <= 11'h080;
    gpio <= 11'h7FF;
    step(8);
    chk({31'h0, link}, 32'h0);
    s3 <= 1'b1;
    step(8);
    chk({31'h0, link}, 32'h1);
    s3 <= 1'b0;
    s0 <= 1'b1;
    step(8);
    chk({31'h0, link}, 32'h1);
    s0 <= 1'b0;
    gpio <= 11'h000;
  endtask

  // disabled event is dropped, enabled one waits for the next poll
  task automatic t_event();
    wb(1, gwie_pkg::OFF_EPCTL, 32'h00080000);
    step(40);
    c = pkts;
    ev <= 9'h080;
    step(1);
    ev <= 9'h000;
    step(40);
    chk(pkts, c);
    ev <= 9'h100;
    step(1);
    ev <= 9'h000;
    step(40);
    chk(pkts, c + 32'h1);
    chk({12'h0, last}, 32'h80000);
    // only pin two may report when all pins rise at once
    wb(1, gwie_pkg::OFF_EPCTL, 32'h00000004);
    c = pkts;
    gpio <= 11'h7FF;
    step(40);
    chk(pkts, c + 32'h1);
    chk({12'h0, last}, 32'h00004);
    gpio <= 11'h000;
  endtask

  task automatic t_irq();
    wb(0, gwie_pkg::OFF_IRQ_STATUS, 0);
    chk(q & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wb(1, gwie_pkg::OFF_IRQ_ENABLE, 32'h1);
    step(3);
    chk({31'h0, irq}, 32'h1);
    wb(1, gwie_pkg::OFF_IRQ_CLEAR, 32'h7);
    step(3);
    chk({31'h0, irq}, 32'h0);
    wb(0, gwie_pkg::OFF_IRQ_STATUS, 0);
    chk(q, 32'h0);
  endtask

  // any 48 cycles hold exactly three poll slots
  task automatic t_always();
    wb(1, gwie_pkg::OFF_EPCTL, 32'h80000000);
    step(20);
    c = pkts;
    step(48);
    chk(pkts - c, 32'h3);
    chk({12'h0, last}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    req = '0;
    pin = 11'h000;
    gpio = 11'h000;
    s0 = 1'b0;
    s3 = 1'b0;
    ev = 9'h000;
    ld = 1'b0;
    usb_rst = 1'b0;
    lite_rst = 1'b0;
    prot = 1'b0;
    prot_usb = 1'b0;
    pres = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    step(2);
    rst <= 1'b0;
    t_fields();
    t_soft();
    t_pin();
    t_link();
    t_event();
    t_irq();
    t_always();
    complete_run();
  end
endmodule // testbench
